/* File: logic/hmrf_defines.vh */
// constants for the mouse report framer
// Overview of operation
// [R1] byte 1: bits 7-5 zero, forward, back, middle, right, left; 3-button builds zero forward/back
// [R2] x low byte is byte 2, x bits 11-8 in byte 3 low nibble
// [R3] y bits 3-0 in byte 3 high nibble, y bits 11-4 are byte 4
// [R4] tilt build: six bytes, byte 5 wheel count, byte 6 tilt count
// [R5] no tilt: five bytes ending with wheel count, same first four bytes
// [R6] media entry: a1, 07, two usage bytes, six zero bytes
// [R7] usage identifier bytes sent low byte first
// [R8] re-trigger control repeats while its button stays pressed
// [R9] host config binds re-trigger controls to single press only; the framer has no such config, re-trigger always repeats while held
// [R10] secure pairing enabled ignores third function slot of each button
// [R11] usages e9 and ea are re-trigger; others linear or switch type; the framer marks e0, e3, e4 linear and e2, e5, e7 switch, any other usage none
// [R12] motion and wheel counts signed, saturate instead of wrapping
`ifndef HMRF_DEFINES_VH
`define HMRF_DEFINES_VH
`define HMRF_MEDIA_PREFIX0  8'hA1
`define HMRF_MEDIA_PREFIX1  8'h07
`define HMRF_MEDIA_LEN      4'h9
`define HMRF_USAGE_VOL_UP   16'h00E9
`define HMRF_USAGE_VOL_DN   16'h00EA
`define HMRF_USAGE_VOLUME   16'h00E0
`define HMRF_USAGE_MUTE     16'h00E2
`define HMRF_USAGE_BASS     16'h00E3
`define HMRF_USAGE_TREBLE   16'h00E4
`define HMRF_USAGE_BOOST    16'h00E5
`define HMRF_USAGE_LOUD     16'h00E7
`define HMRF_MOUSE_LEN_TILT 4'h5
`define HMRF_MOUSE_LEN_NOTW 4'h4
`define HMRF_REPEAT_US      100000
`define HMRF_CLK_MHZ        10
`define HMRF_REPEAT_CYC     (`HMRF_REPEAT_US * `HMRF_CLK_MHZ)
`endif

/* File: logic/hmrf_framer.v */
// mouse and media report framer
`include "hmrf_defines.vh"
module hmrf_framer #(
    parameter REPEAT_CYC = `HMRF_REPEAT_CYC
) (
    input  wire        ref_clk_i,
    input  wire        resetn_i,
    input  wire        five_button_i,
    input  wire        tilt_fitted_i,
    input  wire        ssp_enable_i,
    input  wire        primary_button_bit_i,
    input  wire        secondary_button_bit_i,
    input  wire        middle_button_bit_i,
    input  wire        backward_button_bit_i,
    input  wire        forward_button_bit_i,
    input  wire        motion_valid_i,
    input  wire [11:0] delta_x_i,
    input  wire [11:0] delta_y_i,
    input  wire [7:0]  delta_wheel_i,
    input  wire [7:0]  delta_tilt_i,
    input  wire        mouse_req_i,
    input  wire        media_press_i,
    input  wire        media_release_i,
    input  wire [1:0]  media_slot_i,
    input  wire [15:0] media_usage_i,
    input  wire        out_ready_i,
    output reg         out_valid_o,
    output reg  [7:0]  out_data_o,
    output reg         out_last_o,
    output reg         out_media_o,
    output reg         media_held_o,
    output reg         retrigger_type_o,
    output reg         linear_control_type_o,
    output reg         on_off_control_type_o
);
    localparam S_IDLE  = 3'b001;
    localparam S_MOUSE = 3'b010;
    localparam S_MEDIA = 3'b100;
    reg  [2:0]  state_reg;
    reg  [3:0]  idx_reg;
    reg  [3:0]  len_reg;
    reg  [7:0]  snap_reg [0:5];
    reg  [15:0] usage_reg;
    reg  [15:0] frame_usage_reg;
    reg         media_pend_reg;
    reg         mouse_pend_reg;
    reg  [23:0] rep_cnt_reg;
    wire [11:0] acc_x;
    wire [11:0] acc_y;
    wire [7:0]  acc_z;
    wire [7:0]  acc_t;
    wire        snap_now = (state_reg == S_IDLE) && mouse_pend_reg && !media_pend_reg;
    wire        go_media = (state_reg == S_IDLE) && media_pend_reg;

    function is_retrigger;
        input [15:0] u;
        begin
            // [R11] volume step codes
            is_retrigger = (u == `HMRF_USAGE_VOL_UP) || (u == `HMRF_USAGE_VOL_DN);
        end
    endfunction

    function [1:0] ctl_type;
        input [15:0] u;
        begin
            ctl_type = 2'h0;
            // [R11] linear and switch kinds
            if (u == `HMRF_USAGE_VOLUME || u == `HMRF_USAGE_BASS || u == `HMRF_USAGE_TREBLE)
                ctl_type = 2'h1;
            else if (u == `HMRF_USAGE_MUTE || u == `HMRF_USAGE_BOOST || u == `HMRF_USAGE_LOUD)
                ctl_type = 2'h2;
        end
    endfunction

    function [7:0] media_byte;
        input [3:0]  i;
        input [15:0] u;
        begin
            // [R6] prefix, usage, zeros; [R7] low byte first
            case (i)
                4'h0:    media_byte = `HMRF_MEDIA_PREFIX0;
                4'h1:    media_byte = `HMRF_MEDIA_PREFIX1;
                4'h2:    media_byte = u[7:0];
                4'h3:    media_byte = u[15:8];
                default: media_byte = 8'h00;
            endcase
        end
    endfunction

    hmrf_sat_acc #(.W(12)) u_acc_x (
        .ref_clk_i (ref_clk_i), .resetn_i (resetn_i), .add_i (motion_valid_i),
        .delta_i (delta_x_i), .clear_i (snap_now), .value_o (acc_x));
    hmrf_sat_acc #(.W(12)) u_acc_y (
        .ref_clk_i (ref_clk_i), .resetn_i (resetn_i), .add_i (motion_valid_i),
        .delta_i (delta_y_i), .clear_i (snap_now), .value_o (acc_y));
    hmrf_sat_acc #(.W(8)) u_acc_z (
        .ref_clk_i (ref_clk_i), .resetn_i (resetn_i), .add_i (motion_valid_i),
        .delta_i (delta_wheel_i), .clear_i (snap_now), .value_o (acc_z));
    hmrf_sat_acc #(.W(8)) u_acc_t (
        .ref_clk_i (ref_clk_i), .resetn_i (resetn_i), .add_i (motion_valid_i),
        .delta_i (tilt_fitted_i ? delta_tilt_i : 8'h00), .clear_i (snap_now), .value_o (acc_t));

    // clear while adding folds the new delta into a fresh count, so no motion is lost
    wire       fb = five_button_i & forward_button_bit_i;
    wire       bb = five_button_i & backward_button_bit_i;
    wire       accept = media_press_i && !(ssp_enable_i && media_slot_i == 2'h2);
    wire       cur_rtc = is_retrigger(usage_reg);
    wire       beat_done = out_valid_o && out_ready_i;
    wire [1:0] new_type = ctl_type(media_usage_i);
    wire [3:0] idx_inc = idx_reg + 4'h1;

    integer k;
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg             <= S_IDLE;
            idx_reg               <= 4'h0;
            len_reg               <= 4'h0;
            usage_reg             <= 16'h0000;
            frame_usage_reg       <= 16'h0000;
            media_pend_reg        <= 1'b0;
            mouse_pend_reg        <= 1'b0;
            media_held_o          <= 1'b0;
            rep_cnt_reg           <= 24'h000000;
            out_valid_o           <= 1'b0;
            out_data_o            <= 8'h00;
            out_last_o            <= 1'b0;
            out_media_o           <= 1'b0;
            retrigger_type_o      <= 1'b0;
            linear_control_type_o <= 1'b0;
            on_off_control_type_o <= 1'b0;
            for (k = 0; k < 6; k = k + 1)
                snap_reg[k] <= 8'h00;
        end else begin
            // request arriving with the snapshot stays pending: set wins
            if (mouse_req_i)
                mouse_pend_reg <= 1'b1;
            else if (snap_now)
                mouse_pend_reg <= 1'b0;
            if (accept) begin
                // [R10] third slot dropped under secure pairing
                usage_reg             <= media_usage_i;
                media_held_o          <= 1'b1;
                media_pend_reg        <= 1'b1;
                rep_cnt_reg           <= 24'h000000;
                retrigger_type_o      <= is_retrigger(media_usage_i);
                linear_control_type_o <= new_type[0];
                on_off_control_type_o <= new_type[1];
            end else begin
                if (media_release_i)
                    media_held_o <= 1'b0;
                // [R8] repeat while held
                if (media_held_o && cur_rtc && !media_release_i) begin
                    if (rep_cnt_reg == REPEAT_CYC - 1) begin
                        rep_cnt_reg    <= 24'h000000;
                        media_pend_reg <= 1'b1;
                    end else begin
                        rep_cnt_reg <= rep_cnt_reg + 24'h000001;
                        if (go_media)
                            media_pend_reg <= 1'b0;
                    end
                end else if (go_media) begin
                    media_pend_reg <= 1'b0;
                end
            end
            case (state_reg)
                S_IDLE: begin
                    idx_reg <= 4'h0;
                    if (go_media) begin
                        state_reg   <= S_MEDIA;
                        len_reg     <= `HMRF_MEDIA_LEN;
                        out_valid_o <= 1'b1;
                        out_media_o <= 1'b1;
                        // usage frozen for the whole report, so a press mid-report cannot tear it
                        frame_usage_reg <= usage_reg;
                        out_data_o  <= media_byte(4'h0, usage_reg);
                        out_last_o  <= 1'b0;
                    end else if (snap_now) begin
                        // [R1] button byte
                        snap_reg[0] <= {3'b000, fb, bb, middle_button_bit_i,
                                        secondary_button_bit_i, primary_button_bit_i};
                        // [R2] x split
                        snap_reg[1] <= acc_x[7:0];
                        // [R3] y split
                        snap_reg[2] <= {acc_y[3:0], acc_x[11:8]};
                        snap_reg[3] <= acc_y[11:4];
                        snap_reg[4] <= acc_z;
                        snap_reg[5] <= acc_t;
                        // [R4] six bytes with tilt, [R5] five without
                        len_reg     <= tilt_fitted_i ? `HMRF_MOUSE_LEN_TILT : `HMRF_MOUSE_LEN_NOTW;
                        out_valid_o <= 1'b1;
                        out_media_o <= 1'b0;
                        out_last_o  <= 1'b0;
                        out_data_o  <= {3'b000, fb, bb, middle_button_bit_i,
                                        secondary_button_bit_i, primary_button_bit_i};
                        state_reg   <= S_MOUSE;
                    end
                end
                S_MOUSE: begin
                    if (beat_done) begin
                        if (idx_reg == len_reg) begin
                            out_valid_o <= 1'b0;
                            out_last_o  <= 1'b0;
                            state_reg   <= S_IDLE;
                        end else begin
                            idx_reg    <= idx_inc;
                            out_data_o <= snap_reg[idx_inc[2:0]];
                            out_last_o <= (idx_inc == len_reg);
                        end
                    end
                end
                S_MEDIA: begin
                    if (beat_done) begin
                        if (idx_reg == len_reg) begin
                            out_valid_o <= 1'b0;
                            out_last_o  <= 1'b0;
                            state_reg   <= S_IDLE;
                        end else begin
                            idx_reg    <= idx_inc;
                            // [R6] prefix, usage, zeros; [R7] low byte first
                            out_data_o <= media_byte(idx_inc, frame_usage_reg);
                            out_last_o <= (idx_inc == len_reg);
                        end
                    end
                end
                default: begin
                    state_reg   <= S_IDLE;
                    out_valid_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: logic/hmrf_sat_acc.v */
// saturating signed accumulator for motion and wheel counts
`include "hmrf_defines.vh"
module hmrf_sat_acc #(
    parameter W = 12
) (
    input  wire         ref_clk_i,
    input  wire         resetn_i,
    input  wire         add_i,
    input  wire [W-1:0] delta_i,
    input  wire         clear_i,
    output reg  [W-1:0] value_o
);
    wire [W:0] sum = {value_o[W-1], value_o} + {delta_i[W-1], delta_i};
    wire [W:0] base = clear_i ? {(W+1){1'b0}} : sum;
    wire [W:0] fresh = {delta_i[W-1], delta_i};
    wire [W:0] pick = clear_i ? fresh : sum;
    reg  [W-1:0] value_next;
    always @* begin
        value_next = value_o;
        if (add_i) begin
            // [R12] clamp at overflow
            if (pick[W] != pick[W-1])
                value_next = pick[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
            else
                value_next = pick[W-1:0];
        end else if (clear_i) begin
            value_next = base[W-1:0];
        end
    end
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            value_o <= {W{1'b0}};
        else
            value_o <= value_next;
    end
endmodule

/* File: test/hmrf_framer_properties.sv */
// port-level assertions for the report framer
module hmrf_framer_props (
    input logic       ref_clk_i,
    input logic       resetn_i,
    input logic       five_button_i,
    input logic       tilt_fitted_i,
    input logic       ssp_enable_i,
    input logic       media_press_i,
    input logic [1:0] media_slot_i,
    input logic       out_ready_i,
    input logic       out_valid_o,
    input logic [7:0] out_data_o,
    input logic       out_last_o,
    input logic       out_media_o,
    input logic       media_held_o,
    input logic       retrigger_type_o,
    input logic       linear_control_type_o,
    input logic       on_off_control_type_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    wire        hs = out_valid_o && out_ready_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // byte index inside the current report
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            cnt_reg <= 4'h0;
        else if (hs)
            cnt_reg <= out_last_o ? 4'h0 : cnt_reg + 4'h1;
    end
    hold_stable_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
        && $stable(out_last_o)) else $error("byte changed while stalled");
    gap_after_last_a: assert property (hs && out_last_o |=> !out_valid_o) else $error("no idle after report");
    btn_top_zero_a: assert property (out_valid_o && !out_media_o && cnt_reg == 4'h0 |->
        out_data_o[7:5] == 3'h0) else $error("button byte top bits set");
    three_btn_a: assert property (out_valid_o && !out_media_o && cnt_reg == 4'h0 && !five_button_i |->
        out_data_o[4:3] == 2'h0) else $error("forward or back set for three buttons");
    mouse_len_a: assert property (hs && out_last_o && !out_media_o |->
        cnt_reg == (tilt_fitted_i ? 4'h5 : 4'h4)) else $error("mouse report length wrong");
    media_len_a: assert property (hs && out_last_o && out_media_o |-> cnt_reg == 4'h9)
        else $error("media report length wrong");
    media_head_a: assert property (out_valid_o && out_media_o && cnt_reg < 4'h2 |->
        out_data_o == (cnt_reg == 4'h0 ? 8'hA1 : 8'h07)) else $error("media prefix wrong");
    media_tail_a: assert property (out_valid_o && out_media_o && cnt_reg > 4'h3 |->
        out_data_o == 8'h00) else $error("media tail not zero");
    type_excl_a: assert property ($onehot0({retrigger_type_o, linear_control_type_o,
        on_off_control_type_o})) else $error("more than one control type");
    slot_skip_a: assert property (ssp_enable_i && media_press_i && media_slot_i == 2'h2 && !media_held_o
        |=> !media_held_o) else $error("third slot taken under secure pairing");
    cover property (hs && out_last_o && out_media_o);
    cover property (hs && out_last_o && !out_media_o && tilt_fitted_i);
    cover property (out_valid_o && !out_ready_i);
endmodule
bind hmrf_framer hmrf_framer_props hmrf_framer_props_i (
    .ref_clk_i             (ref_clk_i),
    .resetn_i              (resetn_i),
    .five_button_i         (five_button_i),
    .tilt_fitted_i         (tilt_fitted_i),
    .ssp_enable_i          (ssp_enable_i),
    .media_press_i         (media_press_i),
    .media_slot_i          (media_slot_i),
    .out_ready_i           (out_ready_i),
    .out_valid_o           (out_valid_o),
    .out_data_o            (out_data_o),
    .out_last_o            (out_last_o),
    .out_media_o           (out_media_o),
    .media_held_o          (media_held_o),
    .retrigger_type_o      (retrigger_type_o),
    .linear_control_type_o (linear_control_type_o),
    .on_off_control_type_o (on_off_control_type_o)
);

/* File: test/hmrf_host_sink.sv */
// host side byte sink, prompt or stalling every other cycle
module hmrf_host_sink (
    input  logic       clk_i,
    input  logic       valid_i,
    input  logic [7:0] data_i,
    input  logic       last_i,
    input  logic       slow_i,
    output logic       ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  rx_q[$];
    int          n_frames = 0;
    logic [15:0] usage = 16'h0000;
    initial ready_o = 1'b0;
    always @(posedge clk_i) begin
        if (valid_i && ready_o) begin
            rx_q.push_back(data_i);
            if (last_i)
                n_frames++;
            if (rx_q.size() == 4)
                usage = {data_i, rx_q[2]};
        end
        ready_o <= slow_i ? ~ready_o : 1'b1;
    end
endmodule

/* File: test/tb_top.sv */
// self-checking testbench for the report framer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 0, resetn_i = 0, fb = 0, tl = 0, sp = 0, mv = 0, mq = 0, mp = 0, mr = 0, slow = 0;
    logic [4:0]  btn = 0;
    logic [11:0] dx = 0, dy = 0;
    logic [7:0]  dw = 0, dt = 0, dat;
    logic [1:0]  sl = 0;
    logic [15:0] us = 0;
    logic        rdy, vld, lst, med, held, rt, lc, oo;
    int          fails = 0, n_tests = 0, f0;
    logic [15:0] ut[8] = '{16'h00E0, 16'h00E2, 16'h00E3, 16'h00E4, 16'h00E5, 16'h00E7, 16'h00E9, 16'h00EA};
    logic [2:0]  tt[8] = '{3'h2, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h4};
    // short repeat period keeps the held-button run brief
    hmrf_framer #(.REPEAT_CYC(20)) hmrf_framer_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .five_button_i(fb), .tilt_fitted_i(tl), .ssp_enable_i(sp), .primary_button_bit_i(btn[0]),
        .secondary_button_bit_i(btn[1]), .middle_button_bit_i(btn[2]), .backward_button_bit_i(btn[3]),
        .forward_button_bit_i(btn[4]), .motion_valid_i(mv), .delta_x_i(dx), .delta_y_i(dy), .delta_wheel_i(dw),
        .delta_tilt_i(dt), .mouse_req_i(mq), .media_press_i(mp), .media_release_i(mr), .media_slot_i(sl),
        .media_usage_i(us), .out_ready_i(rdy), .out_valid_o(vld), .out_data_o(dat), .out_last_o(lst),
        .out_media_o(med), .media_held_o(held), .retrigger_type_o(rt), .linear_control_type_o(lc),
        .on_off_control_type_o(oo));
    hmrf_host_sink hmrf_host_sink_i (.clk_i(ref_clk_i), .valid_i(vld), .data_i(dat), .last_i(lst),
        .slow_i(slow), .ready_o(rdy));
    initial forever #50 ref_clk_i = ~ref_clk_i;
    task automatic tick(int n = 1);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_fr(int n);
        for (int t = 0; t < 400 && hmrf_host_sink_i.n_frames < n; t++)
            tick();
        chk("frame count", n, hmrf_host_sink_i.n_frames);
    endtask
    task automatic mouse(logic f, t, s, logic [4:0] b, logic [11:0] x, y, logic [7:0] w, z, int n,
                         logic [47:0] e);
        {fb, tl, slow, btn, dx, dy, dw, dt} = {f, t, s, b, x, y, w, z};
        mv = 1;
        tick(n);
        mv = 0;
        hmrf_host_sink_i.rx_q.delete();
        f0 = hmrf_host_sink_i.n_frames;
        mq = 1;
        tick();
        mq = 0;
        wait_fr(f0 + 1);
        chk("mouse length", t ? 6 : 5, hmrf_host_sink_i.rx_q.size());
        chk("mouse media flag", 0, med);
        for (int k = 0; k < (t ? 6 : 5); k++)
            chk("mouse byte", e[47-8*k -: 8], hmrf_host_sink_i.rx_q[k]);
        $display("done mouse report");
    endtask
    task automatic press(logic [1:0] s, logic [15:0] u);
        hmrf_host_sink_i.rx_q.delete();
        f0 = hmrf_host_sink_i.n_frames;
        {sl, us, mp} = {s, u, 1'b1};
        tick();
        mp = 0;
    endtask
    task automatic release_wait(int n);
        mr = 1;
        tick();
        mr = 0;
        tick(n);
    endtask
    task automatic media(logic [1:0] s, logic [15:0] u, logic [2:0] ty);
        press(s, u);
        wait_fr(f0 + 1);
        chk("media head", 16'hA107, {hmrf_host_sink_i.rx_q[0], hmrf_host_sink_i.rx_q[1]});
        chk("media usage", u, hmrf_host_sink_i.usage);
        for (int k = 4; k < 10; k++)
            chk("media tail", 0, hmrf_host_sink_i.rx_q[k]);
        chk("control type", ty, {rt, lc, oo});
        chk("media flag", 1, med);
        release_wait(40);
        $display("done media report");
    endtask
    task automatic retrig;
        press(2'h0, 16'h00E9);
        wait_fr(f0 + 3);
        chk("held flag", 1, held);
        f0 = hmrf_host_sink_i.n_frames;
        release_wait(60);
        chk("repeat stops", 1, hmrf_host_sink_i.n_frames - f0 <= 1);
        chk("held after release", 0, held);
        $display("done re-trigger");
    endtask
    task automatic ssp_slot;
        sp = 1;
        press(2'h2, 16'h00E2);
        tick(30);
        chk("third slot frames", f0, hmrf_host_sink_i.n_frames);
        media(2'h1, 16'h0225, 3'h0);
        sp = 0;
        media(2'h2, 16'h00CD, 3'h0);
        $display("done secure pairing");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        tick(4);
        resetn_i = 1;
        tick();
        mouse(1, 1, 0, 5'h15, 12'h123, 12'h456, 8'h05, 8'hFE, 1, 48'h1523614505FE);
        mouse(0, 0, 1, 5'h1F, 12'h800, 12'h7FF, 8'h80, 8'h00, 2, 48'h0700F87F8000);
        slow = 0;
        for (int i = 0; i < 8; i++)
            media(2'h0, ut[i], tt[i]);
        retrig();
        ssp_slot();
        tally_and_finish();
    end
    // whole run needs about seven hundred cycles
    initial begin
        #600000;
        fails++;
        tally_and_finish();
    end
endmodule
